// file: fiav_pkg.sv
package fiav_pkg;
  // Source index order equals priority order, 0 is highest
  localparam int unsigned NUM_SRC = 14;
  localparam int unsigned SRC_W = 4;
  // Vector bytes
  localparam logic [7:0] VEC_BASE = 8'h80;
  localparam logic [7:0] VEC_STEP = 8'h04;
  localparam logic [7:0] VEC_NONE = 8'h00;
  // Program memory locations of the shared interrupt entry
  localparam logic [15:0] ENTRY_ADDR = 16'h0053;
  localparam logic [15:0] PAGE_ADDR = 16'h0054;
  localparam logic [15:0] VECLO_ADDR = 16'h0055;
  // Register map (byte addresses)
  localparam logic [3:0] SETUP_OFS = 4'h0;
  localparam logic [3:0] STATUS_OFS = 4'h4;
  localparam logic [3:0] PAGE_OFS = 4'h8;
  localparam logic [3:0] FIXED_OFS = 4'hc;
  localparam int unsigned SETUP_AV_BIT = 0;
  localparam int unsigned STATUS_PEND_BIT = 16;
  localparam logic SETUP_RST = 1'b0;
  localparam logic [7:0] PAGE_RST = 8'h00;
  localparam logic [7:0] FIXED_RST = 8'h00;
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;
endpackage : fiav_pkg

// file: fiav_prio_enc.sv
`timescale 1ns/100ps
module fiav_prio_enc (
  // Sources, bit 0 highest priority
  input wire logic [13:0] src,
  // Result
  output logic any,
  output logic [3:0] idx,
  output logic [7:0] vec
);
  function automatic logic [7:0] fiav_vec_of(input logic [3:0] i);
    fiav_vec_of = fiav_pkg::VEC_BASE + 8'(fiav_pkg::VEC_STEP * {4'h0, i});
  endfunction : fiav_vec_of

  always_comb begin
    any = 1'b0;
    idx = 4'h0;
    for (int i = fiav_pkg::NUM_SRC - 1; i >= 0; i--) begin
      if (src[i]) begin
        any = 1'b1;
        idx = 4'(i);
      end
    end
    vec = any ? fiav_vec_of(idx) : fiav_pkg::VEC_NONE;
  end
endmodule : fiav_prio_enc

// file: fiav_autovector.sv
// What this block does
// - Fourteen sources rank: level flags ep2..ep8, empty flags, full flags, done, trigger.
// - Level flags of endpoints 2,4,6,8 encode to 80,84,88,8c.
// - Empty flags of endpoints 2,4,6,8 encode to 90,94,98,9c.
// - Full flags of endpoints 2,4,6,8 encode to a0,a4,a8,ac.
// - Waveform done encodes to b0 and waveform trigger to b4, the lowest two.
// - With autovector enabled the fetched byte is replaced by the top pending vector.
// - The vector is the low byte at 0055, the software page byte sits at 0054.
// - The core jumps to 0053 after pushing its program counter; the entry holds a jump.
//
// Implementation choices: register access over AXI4-Lite and the register offsets.
`timescale 1ns/100ps
module fiav_autovector (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite slave
  input wire logic [3:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [3:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Interrupt sources from the endpoint FIFOs and waveform engine
  input wire logic ep_two_level_flag,
  input wire logic ep_four_level_flag,
  input wire logic ep_six_level_flag,
  input wire logic ep_eight_level_flag,
  input wire logic ep_two_empty_flag,
  input wire logic ep_four_empty_flag,
  input wire logic ep_six_empty_flag,
  input wire logic ep_eight_empty_flag,
  input wire logic ep_two_full_flag,
  input wire logic ep_four_full_flag,
  input wire logic ep_six_full_flag,
  input wire logic ep_eight_full_flag,
  input wire logic waveform_done_irq,
  input wire logic waveform_trigger_irq,
  // Core code fetch
  input wire logic fetch_valid,
  input wire logic [15:0] fetch_addr,
  input wire logic [7:0] fetch_mem_data,
  output logic [7:0] fetch_data,
  // Shared interrupt line and live vector
  output logic shared_irq,
  output logic [7:0] shared_irq_vector_byte
);
  logic [13:0] src;
  logic any;
  logic [3:0] idx;
  logic [7:0] vec;
  logic autovector_enable;
  logic [7:0] page_byte;
  logic [7:0] fixed_byte;
  logic aw_held;
  logic w_held;
  logic [3:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  logic do_write;
  logic [7:0] next_fetch;

  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);

  // Index order is priority order
  assign src = {waveform_trigger_irq, waveform_done_irq,
                ep_eight_full_flag, ep_six_full_flag, ep_four_full_flag, ep_two_full_flag,
                ep_eight_empty_flag, ep_six_empty_flag, ep_four_empty_flag, ep_two_empty_flag,
                ep_eight_level_flag, ep_six_level_flag, ep_four_level_flag, ep_two_level_flag};

  fiav_prio_enc u_enc (
    .src(src),
    .any(any),
    .idx(idx),
    .vec(vec)
  );

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      shared_irq <= 1'b0;
      shared_irq_vector_byte <= fiav_pkg::VEC_NONE;
    end else begin
      shared_irq <= any;
      shared_irq_vector_byte <= vec;
    end
  end

  // Fetch substitution; the core itself vectors to the entry and pushes its PC
  always_comb begin
    next_fetch = fetch_mem_data;
    if (fetch_addr == fiav_pkg::VECLO_ADDR) begin
      if (autovector_enable && any) begin
        next_fetch = vec;
      end else begin
        next_fetch = fixed_byte;
      end
    end else if (fetch_addr == fiav_pkg::PAGE_ADDR) begin
      next_fetch = page_byte;
    end
  end

  // One cycle fetch latency, matching a registered program memory
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      fetch_data <= 8'h00;
    end else if (fetch_valid) begin
      fetch_data <= next_fetch;
    end
  end

  // Write channel: address and data taken in either order
  assign do_write = aw_held && w_held && !s_axi_bvalid;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b0;
      aw_held <= 1'b0;
      aw_addr <= 4'h0;
    end else begin
      s_axi_awready <= !aw_held && !s_axi_awready && s_axi_awvalid;
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end else if (do_write) begin
        aw_held <= 1'b0;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_wready <= 1'b0;
      w_held <= 1'b0;
      w_data <= 32'h0;
      w_strb <= 4'h0;
    end else begin
      s_axi_wready <= !w_held && !s_axi_wready && s_axi_wvalid;
      if (s_axi_wvalid && s_axi_wready) begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end else if (do_write) begin
        w_held <= 1'b0;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      autovector_enable <= fiav_pkg::SETUP_RST;
      page_byte <= fiav_pkg::PAGE_RST;
      fixed_byte <= fiav_pkg::FIXED_RST;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= fiav_pkg::RESP_OKAY;
    end else begin
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
      if (do_write) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= fiav_pkg::RESP_OKAY;
        if (aw_addr == fiav_pkg::SETUP_OFS) begin
          if (w_strb[0]) begin
            autovector_enable <= w_data[fiav_pkg::SETUP_AV_BIT];
          end
        end else if (aw_addr == fiav_pkg::PAGE_OFS) begin
          if (w_strb[0]) begin
            page_byte <= w_data[7:0];
          end
        end else if (aw_addr == fiav_pkg::FIXED_OFS) begin
          if (w_strb[0]) begin
            fixed_byte <= w_data[7:0];
          end
        end else if (aw_addr != fiav_pkg::STATUS_OFS) begin
          s_axi_bresp <= fiav_pkg::RESP_SLVERR;
        end
      end
    end
  end

  // Read channel; status is read-only, writes to it are ignored
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0;
      s_axi_rresp <= fiav_pkg::RESP_OKAY;
    end else begin
      s_axi_arready <= !s_axi_arready && !s_axi_rvalid && s_axi_arvalid;
      if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp <= fiav_pkg::RESP_OKAY;
        s_axi_rdata <= 32'h0;
        if (s_axi_araddr == fiav_pkg::SETUP_OFS) begin
          s_axi_rdata[fiav_pkg::SETUP_AV_BIT] <= autovector_enable;
        end else if (s_axi_araddr == fiav_pkg::STATUS_OFS) begin
          s_axi_rdata <= {15'h0, any, 2'h0, src};
          s_axi_rdata[31:24] <= vec;
        end else if (s_axi_araddr == fiav_pkg::PAGE_OFS) begin
          s_axi_rdata[7:0] <= page_byte;
        end else if (s_axi_araddr == fiav_pkg::FIXED_OFS) begin
          s_axi_rdata[7:0] <= fixed_byte;
        end else begin
          s_axi_rresp <= fiav_pkg::RESP_SLVERR;
        end
      end
    end
  end

  top_prio_a: assert property (src[0] |=> shared_irq_vector_byte == 8'h80)
    else $error("level flag of ep two not top vector");
  empty_vec_a: assert property (src[4:0] == 5'h10 |=> shared_irq_vector_byte == 8'h90)
    else $error("empty vector wrong");
  full_vec_a: assert property (src[11:0] == 12'h800 |=> shared_irq_vector_byte == 8'hac)
    else $error("full vector wrong");
  wave_vec_a: assert property (src == 14'h2000 |=> shared_irq_vector_byte == 8'hb4)
    else $error("trigger vector wrong");
  done_prio_a: assert property (src[13:12] == 2'b11 && src[11:0] == 12'h0
    |=> shared_irq_vector_byte == 8'hb0)
    else $error("done must beat trigger");
  av_subst_a: assert property (fetch_valid && fetch_addr == 16'h0055 && autovector_enable && any
    |=> fetch_data == $past(vec))
    else $error("vector not substituted");
  page_byte_a: assert property (fetch_valid && fetch_addr == 16'h0054
    |=> fetch_data == $past(page_byte))
    else $error("page byte not presented");
  fixed_byte_a: assert property (fetch_valid && fetch_addr == 16'h0055 && !autovector_enable
    |=> fetch_data == $past(fixed_byte))
    else $error("fixed byte not presented");
  pass_entry_a: assert property (fetch_valid && fetch_addr == 16'h0053
    |=> fetch_data == $past(fetch_mem_data))
    else $error("entry jump byte altered");
  irq_line_a: assert property (any |=> shared_irq)
    else $error("line not raised");
  irq_drop_a: assert property (!any |=> !shared_irq)
    else $error("line not dropped");

  subst_c: cover property (fetch_valid && fetch_addr == 16'h0055 && autovector_enable && any);
  multi_c: cover property ($countones(src) > 1);
  write_c: cover property (do_write);
  read_c: cover property (s_axi_rvalid && s_axi_rready);
endmodule : fiav_autovector

// file: fiav_core_model.sv
`timescale 1ns/100ps
module fiav_core_model (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Interrupt entry request and results
  input wire logic take_irq,
  output logic busy,
  output logic [7:0] seen_page,
  output logic [7:0] seen_low,
  // Code fetch
  output logic fetch_valid,
  output logic [15:0] fetch_addr,
  output logic [7:0] fetch_mem_data,
  input wire logic [7:0] fetch_data
);
  logic [1:0] step;
  // Pattern differs per address, so a stale byte cannot pass for a fresh one
  assign fetch_mem_data = ~fetch_addr[7:0];
  // Stack push is data memory traffic and is not modelled
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      busy <= 1'b0;
      step <= 2'h0;
      fetch_valid <= 1'b0;
      fetch_addr <= 16'h0000;
    end else if (take_irq && !busy) begin
      busy <= 1'b1;
      step <= 2'h0;
      fetch_valid <= 1'b1;
      fetch_addr <= fiav_pkg::ENTRY_ADDR;
    end else if (busy) begin
      step <= step + 2'h1;
      if (step < 2'h2) fetch_addr <= fetch_addr + 16'h0001;
      if (step == 2'h2) begin
        fetch_valid <= 1'b0;
        seen_page <= fetch_data;
      end
      if (step == 2'h3) begin
        seen_low <= fetch_data;
        busy <= 1'b0;
      end
    end
  end
endmodule : fiav_core_model

// file: fiav_autovector_bench.sv
`timescale 1ns/100ps
module fiav_autovector_bench;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [3:0] awaddr = 4'h0, araddr = 4'h0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [31:0] wdata = 32'h0;
  logic awready, wready, bvalid, arready, rvalid, irq, fv, take_irq = 1'b0, busy;
  logic [1:0] bresp, rresp, r;
  logic [31:0] rdata, d;
  logic [13:0] src = 14'h0000;
  logic [15:0] fa;
  logic [7:0] fmd, fd, vec, page, low;
  // Documented vector bytes, lowest byte is the top-priority source
  localparam logic [111:0] VEC_TAB = {8'hb4, 8'hb0, 8'hac, 8'ha8, 8'ha4, 8'ha0, 8'h9c,
    8'h98, 8'h94, 8'h90, 8'h8c, 8'h88, 8'h84, 8'h80};
  int errors = 0;
  int total_checks = 0;
  always #20 aclk = ~aclk;
  fiav_autovector dut (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .ep_two_level_flag(src[0]), .ep_four_level_flag(src[1]), .ep_six_level_flag(src[2]),
    .ep_eight_level_flag(src[3]), .ep_two_empty_flag(src[4]), .ep_four_empty_flag(src[5]),
    .ep_six_empty_flag(src[6]), .ep_eight_empty_flag(src[7]), .ep_two_full_flag(src[8]),
    .ep_four_full_flag(src[9]), .ep_six_full_flag(src[10]), .ep_eight_full_flag(src[11]),
    .waveform_done_irq(src[12]), .waveform_trigger_irq(src[13]),
    .fetch_valid(fv), .fetch_addr(fa), .fetch_mem_data(fmd), .fetch_data(fd),
    .shared_irq(irq), .shared_irq_vector_byte(vec));
  fiav_core_model core (.aclk(aclk), .aresetn(aresetn), .take_irq(take_irq), .busy(busy),
    .seen_page(page), .seen_low(low), .fetch_valid(fv), .fetch_addr(fa),
    .fetch_mem_data(fmd), .fetch_data(fd));
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    total_checks++;
    if (g !== e) begin
      errors++;
      $display("[FAIL] %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  task automatic axw(input logic [3:0] a, input logic [31:0] v, output logic [1:0] rs);
    @(posedge aclk);
    awaddr <= a;
    wdata <= v;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (!bvalid);
    rs = bresp;
    bready <= 1'b0;
  endtask : axw
  task automatic axr(input logic [3:0] a, output logic [31:0] v, output logic [1:0] rs);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
    end while (!rvalid);
    v = rdata;
    rs = rresp;
    rready <= 1'b0;
  endtask : axr
  // Core takes the shared interrupt and fetches the entry bytes
  task automatic take;
    @(posedge aclk);
    take_irq <= 1'b1;
    @(posedge aclk);
    take_irq <= 1'b0;
    do @(posedge aclk); while (busy);
  endtask : take
  task automatic tally_and_finish;
    $display("checks %0d errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : tally_and_finish
  initial begin
    #(40 * 20000);
    errors++;
    tally_and_finish();
  end
  initial begin
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    axr(fiav_pkg::SETUP_OFS, d, r);
    chk("setup", 32'h0, d);
    axr(fiav_pkg::PAGE_OFS, d, r);
    chk("page", 32'h0, d);
    axr(fiav_pkg::FIXED_OFS, d, r);
    chk("fixed", 32'h0, d);
    axw(fiav_pkg::PAGE_OFS, 32'h12, r);
    axw(fiav_pkg::FIXED_OFS, 32'h5a, r);
    chk("bresp", fiav_pkg::RESP_OKAY, r);
    axw(fiav_pkg::STATUS_OFS, 32'hffffffff, r);
    chk("bresp status", fiav_pkg::RESP_OKAY, r);
    axw(4'h2, 32'h1, r);
    chk("bresp unmapped", fiav_pkg::RESP_SLVERR, r);
    axr(fiav_pkg::PAGE_OFS, d, r);
    chk("page rb", 32'h12, d);
    axr(4'h2, d, r);
    chk("rresp", fiav_pkg::RESP_SLVERR, r);
    src <= 14'h0001;
    take();
    chk("low off", 32'h5a, low);
    chk("page byte", 32'h12, page);
    axw(fiav_pkg::SETUP_OFS, 32'h1, r);
    axr(fiav_pkg::SETUP_OFS, d, r);
    chk("setup rb", 32'h1, d);
    // Each pass leaves all lower-priority sources pending as well
    for (int i = 0; i < 14; i++) begin
      src <= 14'(14'h3fff << i);
      repeat (3) @(posedge aclk);
      chk("vector", VEC_TAB[8 * i +: 8], vec);
      chk("irq", 32'h1, irq);
      axr(fiav_pkg::STATUS_OFS, d, r);
      chk("status vec", VEC_TAB[8 * i +: 8], d[31:24]);
      chk("status src", 14'(14'h3fff << i), d[13:0]);
      chk("status any", 32'h1, d[16]);
      take();
      chk("low on", VEC_TAB[8 * i +: 8], low);
    end
    src <= 14'h0000;
    repeat (3) @(posedge aclk);
    chk("irq idle", 32'h0, irq);
    take();
    chk("low idle", 32'h5a, low);
    tally_and_finish();
  end
endmodule : fiav_autovector_bench
